/* File: dcs_defines.vh */
// constants for the debug clock switch block
// assumes inclusion by dcs_debug_clock_switch.v only
`ifndef DCS_DEFINES_VH
`define DCS_DEFINES_VH

// ----------------------------------------------------------------
// tap instruction codes and scan chain numbers
// ----------------------------------------------------------------
`define DCS_INSTR_BYPASS 4'hF
`define DCS_INSTR_INTEST 4'hC
`define DCS_INSTR_EXTEST 4'h0
`define DCS_CHAIN_ZERO 4'h0
`define DCS_CHAIN_DATA 4'h1

// ----------------------------------------------------------------
// program counter advance, in word addresses
// ----------------------------------------------------------------
`define DCS_PC_BREAK_ENTRY 3'h4
`define DCS_PC_DEBUG_INSTR 3'h1
`define DCS_PC_SYS_ACCESS 3'h3

// ----------------------------------------------------------------
// chain lengths and synchroniser layout
// ----------------------------------------------------------------
`define DCS_CHAIN1_LEN 33
`define DCS_SYNC_W 14
`define DCS_SYNC_IDLE 14'h0104
`define DCS_S_MCLK 0
`define DCS_S_TCK 1
`define DCS_S_WAIT 2
`define DCS_S_RTI 3
`define DCS_S_DBGREQ 4
`define DCS_S_WATCH 5
`define DCS_S_MEMDONE 6
`define DCS_S_BKPT 7
`define DCS_S_MREQ 8
`define DCS_S_IRUPD 9
`define DCS_S_CHUPD 10
`define DCS_S_CAPT 11
`define DCS_S_MEMACC 12
`define DCS_S_FORCE 13

`endif

/* File: dcs_debug_clock_switch.v */
// debug clock switch: picks memory clock or debug clock for the core
// assumes all control inputs are asynchronous pins sampled on clk
// Functional notes
// - run on memory clock, debug clock low (code: intest in run selects the debug clock)
// - debug state clocked only by debug clock
// - selected core clock driven on output
// - wait input ignored on debug clock
// - ack high, then switch at falling edge
// - intest chain0 pulses in idle, extest none
// - one chain1 scan between debug clocks
// - breakpoint bit high marks next system speed
// - bypass resyncs, executes, returns with ack (code returns only after a memory access, else stays in run)
// - extra bit high after system access
// - ack high throughout debug state
// - flush pipeline on debug entry
// - ack may drop unless forced high
// - entry adds four, instruction adds one
// - any mode change allowed in debug
// - chain1 33 bits, bit tells entry cause
// - reset makes bypass current instruction
`timescale 1ns/1ps
`default_nettype none
`include "dcs_defines.vh"

module dcs_debug_clock_switch (
  input wire clk,
  input wire arst_n,
  input wire mclk,
  input wire tck,
  input wire wait_n,
  input wire tapRunIdle,
  input wire debugEntryReq,
  input wire watchpointEntry,
  input wire memAccessDone,
  input wire breakpoint_in,
  input wire coreMemReqN,
  input wire irUpdate,
  input wire [3:0] irValue,
  input wire chainUpdate,
  input wire [3:0] chainValue,
  input wire captureDr,
  input wire loadedIsMemAccess,
  input wire forceAckHigh,
  output wire coreClk,
  output wire debug_core_clock,
  output wire selected_clock_out,
  output wire debug_ack,
  output wire mem_request_n,
  output wire pipelineFlush,
  output wire pcStepValid,
  output wire [2:0] pcStep,
  output wire anyModeChange,
  output wire chain1ExtraBit,
  output wire [3:0] currentInstr
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [4:0] ST_RUN = 5'h01;
  localparam [4:0] ST_ENTRY = 5'h02;
  localparam [4:0] ST_DEBUG = 5'h04;
  localparam [4:0] ST_SYNC = 5'h08;
  localparam [4:0] ST_SYSACC = 5'h10;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire [`DCS_SYNC_W-1:0] asyncIn;
  reg [`DCS_SYNC_W-1:0] syncA_reg;
  reg [`DCS_SYNC_W-1:0] syncB_reg;
  reg [`DCS_SYNC_W-1:0] syncPrev_reg;
  // idle-high pins reset high, so no false request after reset
  localparam [`DCS_SYNC_W-1:0] SYNC_IDLE = `DCS_SYNC_IDLE;
  assign asyncIn = {forceAckHigh, loadedIsMemAccess, captureDr, chainUpdate, irUpdate, coreMemReqN,
                    breakpoint_in, memAccessDone, watchpointEntry, debugEntryReq, tapRunIdle, wait_n, tck, mclk};

  genvar gi;
  generate
    for (gi = 0; gi < `DCS_SYNC_W; gi = gi + 1) begin : gSync
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          syncA_reg[gi] <= SYNC_IDLE[gi];
          syncB_reg[gi] <= SYNC_IDLE[gi];
          syncPrev_reg[gi] <= SYNC_IDLE[gi];
        end else begin
          syncA_reg[gi] <= asyncIn[gi];
          syncB_reg[gi] <= syncA_reg[gi];
          syncPrev_reg[gi] <= syncB_reg[gi];
        end
      end
    end
  endgenerate

  wire mclkS = syncB_reg[`DCS_S_MCLK];
  wire tckS = syncB_reg[`DCS_S_TCK];
  wire mclkFall = syncPrev_reg[`DCS_S_MCLK] & ~mclkS;
  wire tckRise = ~syncPrev_reg[`DCS_S_TCK] & tckS;
  wire entryRise = ~syncPrev_reg[`DCS_S_DBGREQ] & syncB_reg[`DCS_S_DBGREQ];
  wire irUpdRise = ~syncPrev_reg[`DCS_S_IRUPD] & syncB_reg[`DCS_S_IRUPD];
  wire chUpdRise = ~syncPrev_reg[`DCS_S_CHUPD] & syncB_reg[`DCS_S_CHUPD];
  wire captRise = ~syncPrev_reg[`DCS_S_CAPT] & syncB_reg[`DCS_S_CAPT];

  // ----------------------------------------------------------------
  // instruction and scan chain select
  // ----------------------------------------------------------------
  reg [3:0] instr_reg;
  reg [3:0] chain_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_reg <= `DCS_INSTR_BYPASS;
      chain_reg <= `DCS_CHAIN_ZERO;
    end else begin
      if (irUpdRise) begin
        instr_reg <= irValue;
      end
      if (chUpdRise) begin
        chain_reg <= chainValue;
      end
    end
  end
  wire isBypass = (instr_reg == `DCS_INSTR_BYPASS);
  wire isIntest = (instr_reg == `DCS_INSTR_INTEST);
  wire bypassSelected = irUpdRise & (irValue == `DCS_INSTR_BYPASS);

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg sysPending_reg;
  reg sysPending_next;
  reg sysReturn_reg;
  reg sysReturn_next;
  reg firstCapt_reg;
  reg firstCapt_next;
  reg watchEntry_reg;
  reg watchEntry_next;
  reg flush_reg;
  reg flush_next;
  reg pcValid_reg;
  reg pcValid_next;
  reg [2:0] pcStep_reg;
  reg [2:0] pcStep_next;
  reg markPrev_reg;
  reg markPrev_next;

  // test clock only intest on chain0 or chain1 debug
  wire intestClocking = isIntest & syncB_reg[`DCS_S_RTI] &
                        ((chain_reg == `DCS_CHAIN_ZERO) | (chain_reg == `DCS_CHAIN_DATA));
  wire dclkPulse = intestClocking & tckS;
  wire dclkRise = intestClocking & tckRise;

  always @* begin
    state_next = state_reg;
    sysPending_next = sysPending_reg;
    sysReturn_next = sysReturn_reg;
    firstCapt_next = firstCapt_reg;
    watchEntry_next = watchEntry_reg;
    flush_next = 1'b0;
    pcValid_next = 1'b0;
    pcStep_next = pcStep_reg;
    markPrev_next = markPrev_reg;
    case (state_reg)
      ST_RUN: begin
        // ack raised in memory clock high phase
        if (entryRise & mclkS) begin
          state_next = ST_ENTRY;
          watchEntry_next = syncB_reg[`DCS_S_WATCH];
          firstCapt_next = 1'b1;
          sysReturn_next = 1'b0;
          sysPending_next = 1'b0;
          markPrev_next = 1'b0;
          flush_next = 1'b1;
          pcValid_next = 1'b1;
          pcStep_next = `DCS_PC_BREAK_ENTRY;
        end
      end
      ST_ENTRY: begin
        if (mclkFall) begin
          state_next = ST_DEBUG;
        end
      end
      ST_DEBUG: begin
        // each debug clock loads one scanned word
        if (dclkRise) begin
          // word after a marked word runs at system speed
          sysPending_next = markPrev_reg;
          markPrev_next = syncB_reg[`DCS_S_BKPT];
          pcValid_next = 1'b1;
          pcStep_next = `DCS_PC_DEBUG_INSTR;
        end
        if (captRise & (chain_reg == `DCS_CHAIN_DATA)) begin
          firstCapt_next = 1'b0;
        end
        if (bypassSelected & sysPending_reg & ~tckS) begin
          state_next = ST_SYNC;
          sysPending_next = 1'b0;
        end
      end
      ST_SYNC: begin
        // hand over only with memory clock low
        if (mclkFall) begin
          if (syncB_reg[`DCS_S_MEMACC]) begin
            state_next = ST_SYSACC;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_SYSACC: begin
        // return to debug after the access
        if (syncB_reg[`DCS_S_MEMDONE] & mclkS) begin
          state_next = ST_ENTRY;
          sysReturn_next = 1'b1;
          firstCapt_next = 1'b1;
          pcValid_next = 1'b1;
          pcStep_next = `DCS_PC_SYS_ACCESS;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_RUN;
      sysPending_reg <= 1'b0;
      sysReturn_reg <= 1'b0;
      firstCapt_reg <= 1'b0;
      watchEntry_reg <= 1'b0;
      flush_reg <= 1'b0;
      pcValid_reg <= 1'b0;
      pcStep_reg <= 3'h0;
      markPrev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sysPending_reg <= sysPending_next;
      sysReturn_reg <= sysReturn_next;
      firstCapt_reg <= firstCapt_next;
      watchEntry_reg <= watchEntry_next;
      flush_reg <= flush_next;
      pcValid_reg <= pcValid_next;
      pcStep_reg <= pcStep_next;
      markPrev_reg <= markPrev_next;
    end
  end

  // ----------------------------------------------------------------
  // clock selection and outputs
  // ----------------------------------------------------------------
  wire onDebugClk = (state_reg == ST_DEBUG) | (state_reg == ST_SYNC) |
                    ((state_reg == ST_RUN) & ~isBypass & isIntest);
  reg coreClk_reg;
  reg debug_core_clock_reg;
  reg ack_reg;
  reg mreqN_reg;
  reg extra_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      coreClk_reg <= 1'b0;
      debug_core_clock_reg <= 1'b0;
      ack_reg <= 1'b0;
      mreqN_reg <= 1'b1;
      extra_reg <= 1'b0;
    end else begin
      // debug clock low outside debug and intest
      debug_core_clock_reg <= onDebugClk & dclkPulse;
      // wait ignored on debug clock, registered mux
      if (onDebugClk) begin
        coreClk_reg <= dclkPulse;
      end else begin
        coreClk_reg <= mclkS & syncB_reg[`DCS_S_WAIT];
      end
      // ack held in debug, may drop in access
      ack_reg <= (state_next == ST_ENTRY) | (state_next == ST_DEBUG) | (state_next == ST_SYNC) |
                 ((state_next == ST_SYSACC) & syncB_reg[`DCS_S_FORCE]);
      if (state_next == ST_SYSACC) begin
        mreqN_reg <= 1'b0;
      end else if (state_next == ST_RUN) begin
        mreqN_reg <= syncB_reg[`DCS_S_MREQ];
      end else begin
        mreqN_reg <= 1'b1;
      end
      if (firstCapt_reg) begin
        extra_reg <= sysReturn_reg | watchEntry_reg;
      end else begin
        extra_reg <= syncB_reg[`DCS_S_BKPT];
      end
    end
  end

  assign coreClk = coreClk_reg;
  assign selected_clock_out = coreClk_reg;
  assign debug_core_clock = debug_core_clock_reg;
  assign debug_ack = ack_reg;
  assign mem_request_n = mreqN_reg;
  assign pipelineFlush = flush_reg;
  assign pcStepValid = pcValid_reg;
  assign pcStep = pcStep_reg;
  assign anyModeChange = (state_reg == ST_ENTRY) | (state_reg == ST_DEBUG) | (state_reg == ST_SYNC);
  assign chain1ExtraBit = extra_reg;
  assign currentInstr = instr_reg;

endmodule

`default_nettype wire

/* File: dcs_checker.sv */
// checker for the debug clock switch outputs
// assumes binding onto dcs_debug_clock_switch
`timescale 1ns/1ps
`default_nettype none
module dcs_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic coreClk,
  input wire logic debug_core_clock,
  input wire logic selected_clock_out,
  input wire logic debug_ack,
  input wire logic mem_request_n,
  input wire logic pipelineFlush,
  input wire logic pcStepValid,
  input wire logic [2:0] pcStep,
  input wire logic anyModeChange,
  input wire logic chain1ExtraBit,
  input wire logic [3:0] currentInstr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // clock selection
  // ----------------------------------------
  clk_out_a: assert property (selected_clock_out == coreClk)
    else $error("clock output differs from core clock");
  idle_debug_core_clock_a: assert property (!debug_ack && currentInstr != 4'hC |-> !debug_core_clock)
    else $error("debug clock active outside debug");
  core_debug_core_clock_a: assert property (debug_ack && $past(debug_ack, 8) && $past(mem_request_n, 8) && mem_request_n
    |-> coreClk == debug_core_clock)
    else $error("core not on debug clock in debug");
  no_runt_a: assert property ($changed(coreClk) |=> $stable(coreClk))
    else $error("short pulse on core clock");
  extest_a: assert property (currentInstr == 4'h0 && $past(currentInstr) == 4'h0 |-> !debug_core_clock)
    else $error("debug clock under extest");
  // ----------------------------------------
  // entry and system access
  // ----------------------------------------
  entry_pc_a: assert property (pipelineFlush |-> pcStepValid && pcStep == 3'h4 && debug_ack)
    else $error("entry without ack or step of four");
  ack_hold_a: assert property (pipelineFlush |-> debug_ack [*8])
    else $error("ack dropped after entry");
  mode_free_a: assert property (pipelineFlush |=> anyModeChange)
    else $error("mode change not freed in debug");
  sys_step_a: assert property ($rose(debug_ack) && !pipelineFlush |-> pcStepValid && pcStep == 3'h3)
    else $error("return from access without step of three");
  sys_bit_a: assert property (pcStepValid && pcStep == 3'h3 |-> ##[0:1] chain1ExtraBit)
    else $error("extra bit low after access");
  cover property (pipelineFlush);
  cover property (pcStepValid && pcStep == 3'h3);
  cover property ($rose(debug_core_clock));
endmodule
bind dcs_debug_clock_switch dcs_checker u_chk (.*);
`default_nettype wire

/* File: dcs_mem_partner.sv */
// memory controller model: memory clock and access completion
// assumes mem_request_n from the device under test
`timescale 1ns/1ps
`default_nettype none
module dcs_mem_partner (
  input wire logic holdLow,
  input wire logic slow,
  input wire logic mem_request_n,
  output logic mclk = 1'b0,
  output logic memAccessDone = 1'b0
);
  int n = 0;
  always #20 mclk = holdLow ? 1'b0 : ~mclk;
  always @(posedge mclk) begin
    n = mem_request_n ? 0 : n + 1;
    memAccessDone <= !mem_request_n && n > (slow ? 6 : 1);
  end
endmodule
`default_nettype wire

/* File: debug_clock_switch_control_test.sv */
// self-checking bench for the debug clock switch
// assumes dcs_mem_partner and dcs_checker compiled first
`timescale 1ns/1ps
`default_nettype none
module debug_clock_switch_control_test;
  logic clk = 0, arst_n = 0, tck = 0, wait_n = 1, tapRunIdle = 0, debugEntryReq = 0;
  logic breakpoint_in = 0, irUpdate = 0, chainUpdate = 0, loadedIsMemAccess = 0;
  logic forceAckHigh = 0, holdLow = 0, slow = 0, watchpointEntry = 0, coreMemReqN = 1, captureDr = 0;
  logic [3:0] irValue = 4'hF, chainValue = 4'h0;
  wire mclk, memAccessDone, coreClk, debug_core_clock, selected_clock_out, debug_ack, mem_request_n;
  wire pipelineFlush, pcStepValid, anyModeChange, chain1ExtraBit;
  wire [2:0] pcStep;
  wire [3:0] currentInstr;
  logic [2:0] lastStep = 3'h0;
  int mismatches = 0, samples_checked = 0, flushes = 0, rises = 0, n;
  always #2.5 clk = ~clk;
  dcs_debug_clock_switch u_dut (.*);
  dcs_mem_partner u_mem (.holdLow(holdLow), .slow(slow), .mem_request_n(mem_request_n), .mclk(mclk),
    .memAccessDone(memAccessDone));
  always @(posedge clk) begin
    if (pcStepValid === 1'b1) lastStep <= pcStep;
    if (pipelineFlush === 1'b1) flushes++;
  end
  always @(posedge debug_core_clock) rises++;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic upd(input bit c, input logic [3:0] v);
    if (c) chainValue = v;
    else irValue = v;
    step(2);
    if (c) chainUpdate = 1;
    else irUpdate = 1;
    step(4);
    chainUpdate = 0;
    irUpdate = 0;
    step(4);
  endtask
  task automatic pulse(input logic b);
    breakpoint_in = b;
    tapRunIdle = 1;
    step(2);
    tck = 1;
    step(6);
    tck = 0;
    step(6);
    tapRunIdle = 0;
    step(2);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset;
    chk("instr", 4'hF, currentInstr);
    chk("debug_core_clock", 4'h0, {3'h0, debug_core_clock});
  endtask
  task automatic test_entry(input logic w);
    watchpointEntry = w;
    n = flushes;
    @(posedge mclk);
    step(1);
    debugEntryReq = 1;
    for (int i = 0; i < 100 && debug_ack !== 1'b1; i++) step(1);
    debugEntryReq = 0;
    watchpointEntry = 0;
    step(6);
    chk("flush", 4'(n + 1), 4'(flushes));
    chk("entry step", 4'h4, {1'b0, lastStep});
    chk("mode", 4'h1, {3'h0, anyModeChange});
    chk("cause", {3'h0, w}, {3'h0, chain1ExtraBit});
  endtask
  task automatic test_instr;
    upd(1, 4'h1);
    upd(0, 4'hC);
    n = rises;
    wait_n = 0;
    pulse(0);
    wait_n = 1;
    chk("debug_core_clock count", 4'(n + 1), 4'(rises));
    chk("instr step", 4'h1, {1'b0, lastStep});
    chk("ack", 4'h1, {3'h0, debug_ack});
    breakpoint_in = 1;
    captureDr = 1;
    step(6);
    captureDr = 0;
    step(2);
    chk("chain bit", 4'h1, {3'h0, chain1ExtraBit});
    breakpoint_in = 0;
  endtask
  task automatic test_sys(input logic s, input logic f);
    slow = s;
    forceAckHigh = f;
    loadedIsMemAccess = 1;
    pulse(1);
    pulse(0);
    upd(0, 4'hF);
    for (int i = 0; i < 100 && mem_request_n !== 1'b0; i++) step(1);
    step(2);
    chk("req", 4'h0, {3'h0, mem_request_n});
    chk("ack in access", {3'h0, f}, {3'h0, debug_ack});
    for (int i = 0; i < 400 && !(mem_request_n === 1'b1 && debug_ack === 1'b1); i++) step(1);
    step(3);
    chk("sys step", 4'h3, {1'b0, lastStep});
    chk("extra bit", 4'h1, {3'h0, chain1ExtraBit});
    loadedIsMemAccess = 0;
    forceAckHigh = 0;
    upd(0, 4'hC);
  endtask
  task automatic test_exit;
    pulse(1);
    pulse(0);
    upd(0, 4'hF);
    for (int i = 0; i < 100 && debug_ack !== 1'b0; i++) step(1);
    step(10);
    chk("ack out", 4'h0, {3'h0, debug_ack});
    chk("req out", 4'h1, {3'h0, mem_request_n});
    chk("mode out", 4'h0, {3'h0, anyModeChange});
  endtask
  task automatic test_mode;
    holdLow = 1;
    step(20);
    upd(1, 4'h0);
    upd(0, 4'hC);
    n = rises;
    pulse(0);
    chk("intest clk", 4'(n + 1), 4'(rises));
    upd(0, 4'h0);
    pulse(0);
    chk("extest clk", 4'(n + 1), 4'(rises));
    upd(0, 4'hF);
    holdLow = 0;
    arst_n = 0;
    step(2);
    arst_n = 1;
    step(4);
    test_reset();
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 arst_n = 1;
    step(4);
    test_reset();
    test_entry(0);
    test_instr();
    test_sys(0, 0);
    test_sys(1, 1);
    test_exit();
    test_mode();
    test_entry(1);
    finish_test();
  end
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire
